//--- hdl/clock_output_gate.sv
/*
  Glitch-free output gate of a 1:9 differential clock fanout. Both input
  clock pairs, the gate control and the source select arrive as pins and are
  oversampled on sys_clk, which must run well above the input clocks.
*/
`timescale 1ns/1ps
`include "clock_gate_cfg.svh"

module clock_output_gate (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire clock_gate_pkg::diff_pair_type first_clock_input_pair,
  input  wire clock_gate_pkg::diff_pair_type second_clock_input_pair,
  input  wire logic                          output_gate_ctrl,
  input  wire logic                          source_select,
  output logic      [`OUT_PAIR_COUNT-1:0]    true_output_pairs,
  output logic      [`OUT_PAIR_COUNT-1:0]    complement_output_pairs
);

  logic [`PIN_SYNC_WIDTH-1:0]      levels;
  logic                            first_level;
  logic                            second_level;
  logic                            selected_level;
  logic                            selected_prev;
  logic                            rise_event;
  logic                            fall_event;
  clock_gate_pkg::gate_chain_type  chain;

  // One level copied onto every output pair; shared by the output register
  // and the checks so both agree on the fan-out width
  function automatic logic [`OUT_PAIR_COUNT-1:0] fan_out(input logic lvl);
    fan_out = {`OUT_PAIR_COUNT{lvl}};
  endfunction

  // ------------------------------------------------------------------
  // Pin capture
  // ------------------------------------------------------------------
  pin_sync3 pin_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pins    ({source_select, output_gate_ctrl,
               second_clock_input_pair.neg, second_clock_input_pair.pos,
               first_clock_input_pair.neg, first_clock_input_pair.pos}),
    .levels  (levels)
  );

  // ------------------------------------------------------------------
  // Differential receivers and source mux
  // ------------------------------------------------------------------
  // A pair whose legs agree (floating or mid-transition) keeps its old level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      first_level  <= `PAIR_LEVEL_RESET;
      second_level <= `PAIR_LEVEL_RESET;
    end else begin
      if (levels[`PIN_FIRST_POS] != levels[`PIN_FIRST_NEG]) begin
        first_level <= levels[`PIN_FIRST_POS];
      end
      if (levels[`PIN_SECOND_POS] != levels[`PIN_SECOND_NEG]) begin
        second_level <= levels[`PIN_SECOND_POS];
      end
    end
  end

  // Mux is plain combinational; switching source mid-cycle is not deglitched
  assign selected_level = levels[`PIN_SOURCE_SEL] ? second_level : first_level;

  // Edge events of the selected input clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      selected_prev <= `PAIR_LEVEL_RESET;
    end else begin
      selected_prev <= selected_level;
    end
  end

  assign rise_event = selected_level & ~selected_prev;
  assign fall_event = ~selected_level & selected_prev;

  // ------------------------------------------------------------------
  // Gating chain
  // ------------------------------------------------------------------
  // Rising stages sample the control; the retimed copy makes the falling
  // stage see a level one full cycle old, giving the 2.5-cycle latency
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chain.first   <= `GATE_STAGE_RESET;
      chain.second  <= `GATE_STAGE_RESET;
      chain.settled <= `GATE_STAGE_RESET;
    end else if (rise_event) begin
      chain.first   <= levels[`PIN_GATE_CTRL];
      chain.second  <= chain.first;
      chain.settled <= chain.second;
    end
  end

  // Falling stage: the enable moves only while the clock is low
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chain.enable <= `GATE_STAGE_RESET;
    end else if (fall_event) begin
      chain.enable <= chain.settled;
    end
  end

  // ------------------------------------------------------------------
  // Output pairs
  // ------------------------------------------------------------------
  // Enable only flips with the clock low, so a gated edge is never cut short
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      true_output_pairs       <= `TRUE_OUT_RESET;
      complement_output_pairs <= `COMP_OUT_RESET;
    end else if (chain.enable) begin
      true_output_pairs       <= fan_out(selected_level);
      complement_output_pairs <= fan_out(~selected_level);
    end else begin
      true_output_pairs       <= `TRUE_OUT_RESET;
      complement_output_pairs <= `COMP_OUT_RESET;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence rise_seen;
    rise_event;
  endsequence

  sequence enable_changes;
    !$stable(chain.enable);
  endsequence

  // A rise of the selected clock seen while the gate is open
  sequence passing_rise;
    rise_event ##0 chain.enable;
  endsequence

  // The first stage takes the synchronised control level at each rise
  a_capture_first_stage: assert property (
      rise_seen |=> chain.first == $past(levels[`PIN_GATE_CTRL]))
    else $error("first stage did not capture gate control");

  // Between rises the rising stages stay put, so only a rise samples control
  a_stages_hold: assert property (
      !rise_event |=> $stable(chain.first) && $stable(chain.second) && $stable(chain.settled))
    else $error("rising stages moved without an input rise");

  a_second_stage_shift: assert property (rise_seen |=> chain.second == $past(chain.first))
    else $error("second stage did not follow first stage");

  // The retimed copy supplies the extra cycle of the 2.5-cycle latency
  a_settled_shift: assert property (rise_seen |=> chain.settled == $past(chain.second))
    else $error("retimed stage did not follow second stage");

  a_enable_on_fall: assert property (enable_changes |-> $past(fall_event))
    else $error("enable changed without a falling edge");

  a_enable_latency: assert property (enable_changes |-> chain.enable == $past(chain.settled))
    else $error("enable did not take the retimed control level");

  a_low_when_toggled: assert property (enable_changes |-> !$past(selected_level))
    else $error("enable moved while clock was high");

  a_gated_static_levels: assert property (
      $past(!chain.enable) |->
        true_output_pairs == `TRUE_OUT_RESET && complement_output_pairs == `COMP_OUT_RESET)
    else $error("gated outputs not held static");

  // The complement leg is always the exact inverse of the true leg
  a_output_pairing: assert property (
      complement_output_pairs == ~true_output_pairs)
    else $error("complement outputs not inverse of true outputs");

  // All nine pairs carry one and the same level
  a_pairs_identical: assert property (
      true_output_pairs == fan_out(true_output_pairs[0]))
    else $error("output pairs disagree");

  a_disable_holds_off: assert property (
      $fell(chain.enable) |=> (true_output_pairs == `TRUE_OUT_RESET) [*2])
    else $error("outputs toggled right after disable");

  // Once open, every rise of the selected clock reaches the outputs
  a_enable_passes_clock: assert property (
      passing_rise |=> true_output_pairs == fan_out(1'b1))
    else $error("next clock cycle not passed after enable");

  // An output rise can only come from a gate that was already open
  a_rise_only_open: assert property (
      $rose(true_output_pairs[0]) |-> $past(chain.enable))
    else $error("output rose while gate was closed");

  a_source_routing: assert property (
      $past(chain.enable) |-> true_output_pairs
        == fan_out($past(levels[`PIN_SOURCE_SEL]) ? $past(second_level) : $past(first_level)))
    else $error("wrong input pair routed to outputs");

endmodule

//--- include/clock_gate_cfg.svh
/*
  Constants of the glitch-free clock output gate: widths, pin bit positions and
  reset values. Assumes inclusion by its bare name from package and modules.
*/
`ifndef CLOCK_GATE_CFG_SVH
`define CLOCK_GATE_CFG_SVH

// ------------------------------------------------------------------
// Widths
// ------------------------------------------------------------------
`define OUT_PAIR_COUNT     9
`define PIN_SYNC_WIDTH     6

// ------------------------------------------------------------------
// Pin synchroniser bit positions
// ------------------------------------------------------------------
`define PIN_FIRST_POS      0
`define PIN_FIRST_NEG      1
`define PIN_SECOND_POS     2
`define PIN_SECOND_NEG     3
`define PIN_GATE_CTRL      4
`define PIN_SOURCE_SEL     5

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PIN_SYNC_RESET     6'h00
`define TRUE_OUT_RESET     9'h000
`define COMP_OUT_RESET     9'h1ff
`define GATE_STAGE_RESET   1'h0
`define PAIR_LEVEL_RESET   1'h0

`endif

//--- include/clock_gate_pkg.sv
/*
  Types of the glitch-free clock output gate. Assumes clock_gate_cfg.svh
  on the include path.
*/
`include "clock_gate_cfg.svh"

package clock_gate_pkg;

  // One differential pin pair as seen at the pads
  typedef struct packed {
    logic pos;
    logic neg;
  } diff_pair_type;

  // Gating chain: two rising stages, a retimed copy, the falling stage
  typedef struct packed {
    logic first;
    logic second;
    logic settled;
    logic enable;
  } gate_chain_type;

endpackage

//--- hdl/pin_sync3.sv
/*
  Three-flop pin synchroniser with agreement filter for a fixed-width group
  of pins. Assumes pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "clock_gate_cfg.svh"

module pin_sync3 (
  input  wire logic                         sys_clk,
  input  wire logic                         sys_rst,
  input  wire logic [`PIN_SYNC_WIDTH-1:0]   pins,
  output logic      [`PIN_SYNC_WIDTH-1:0]   levels
);

  logic [`PIN_SYNC_WIDTH-1:0] meta;
  logic [`PIN_SYNC_WIDTH-1:0] stage2;
  logic [`PIN_SYNC_WIDTH-1:0] stage3;

  // ------------------------------------------------------------------
  // Synchroniser chain
  // ------------------------------------------------------------------
  // First flop is read only by the second one
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta   <= `PIN_SYNC_RESET;
      stage2 <= `PIN_SYNC_RESET;
      stage3 <= `PIN_SYNC_RESET;
    end else begin
      meta   <= pins;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // Accept a bit only once stages two and three agree, rejecting a
  // settling flop that resolved late
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      levels <= `PIN_SYNC_RESET;
    end else begin
      levels <= (levels & (stage2 ^ stage3)) | (stage3 & ~(stage2 ^ stage3));
    end
  end

endmodule

//--- verif/gate_ctrl_model.sv
/*
  Controller model: two free-running differential input clocks plus the
  gate and select pins. Assumes sys_clk is the bench clock.
*/
`timescale 1ns/1ps

module gate_ctrl_model (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     want_gate,
  input  wire logic                     want_sel,
  output clock_gate_pkg::diff_pair_type first_pair,
  output clock_gate_pkg::diff_pair_type second_pair,
  output logic                          gate_pin,
  output logic                          sel_pin,
  output logic                          tick
);
  logic [3:0] first_phase;
  logic [4:0] second_phase;

  // ------------------------------------------------------------
  // Input clocks
  // ------------------------------------------------------------
  // Periods of 16 and 24 sys_clk so pulse widths tell the sources apart
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      first_phase  <= 4'h0;
      second_phase <= 5'h00;
    end else begin
      first_phase  <= first_phase + 4'h1;
      second_phase <= (second_phase == 5'h17) ? 5'h00 : second_phase + 5'h01;
    end
  end
  assign first_pair  = '{pos: first_phase < 4'h8, neg: first_phase >= 4'h8};
  assign second_pair = '{pos: second_phase < 5'h0c, neg: second_phase >= 5'h0c};

  // ------------------------------------------------------------
  // Control pins
  // ------------------------------------------------------------
  // Pins move three cycles after a selected rise, well clear of the next one
  assign tick = sel_pin ? (second_phase == 5'h02) : (first_phase == 4'h2);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gate_pin <= 1'b0;
      sel_pin  <= 1'b0;
    end else if (tick) begin
      gate_pin <= want_gate;
      sel_pin  <= want_sel;
    end
  end
endmodule

//--- verif/glitchless_clock_output_gate_tb.sv
/*
  Self-checking bench of the clock output gate. Assumes the design files
  and the controller model are compiled first.
*/
`timescale 1ns/1ps

module glitchless_clock_output_gate_tb;
  logic                          sys_clk;
  logic                          sys_rst;
  logic                          want_gate;
  logic                          want_sel;
  logic                          tick;
  logic                          gate_pin;
  logic                          sel_pin;
  clock_gate_pkg::diff_pair_type first_pair;
  clock_gate_pkg::diff_pair_type second_pair;
  logic [8:0]                    true_out;
  logic [8:0]                    comp_out;
  logic [15:0]                   width;
  logic [15:0]                   exp_q[$];
  logic [31:0]                   r;
  integer                        seed;
  int                            bad_count;
  int                            check_count;
  int                            cycles;
  int                            n;

  gate_ctrl_model partner (.sys_clk(sys_clk), .sys_rst(sys_rst), .want_gate(want_gate),
    .want_sel(want_sel), .first_pair(first_pair), .second_pair(second_pair),
    .gate_pin(gate_pin), .sel_pin(sel_pin), .tick(tick));

  clock_output_gate DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .first_clock_input_pair(first_pair), .second_clock_input_pair(second_pair),
    .output_gate_ctrl(gate_pin), .source_select(sel_pin),
    .true_output_pairs(true_out), .complement_output_pairs(comp_out));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] expected);
    check_count++;
    if (seen !== expected) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask

  task stop_test;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Tick is looked at off the edge, so the model's update never races it
  task wait_ticks(input int count);
    repeat (count) begin
      do @(negedge sys_clk); while (tick !== 1'b1);
      @(posedge sys_clk);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Hang guard: the whole run needs well under a fifth of this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test;
    end
  end

  // ------------------------------------------------------------
  // Output monitor
  // ------------------------------------------------------------
  // Every high pulse must be a full half period of the chosen source
  always @(negedge sys_clk) begin
    check({7'h00, comp_out}, {7'h00, ~true_out});
    check({7'h00, true_out}, {7'h00, {9{true_out[0]}}});
    if (sys_rst)
      check({7'h00, true_out}, 16'h0000);
    else if (true_out[0])
      width = width + 16'h0001;
    else if (width != 16'h0000) begin
      check(width, (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000);
      width = 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  // A gate level held n periods, set after a rise, yields exactly n pulses
  initial begin
    seed = 26;
    width = 16'h0000;
    sys_rst = 1'b1;
    want_gate = 1'b0;
    want_sel = 1'b0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_ticks(4);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      n = 3 + int'(r[1:0]);
      want_sel <= i[0] ^ r[4];
      wait_ticks(3);
      want_gate <= 1'b1;
      repeat (n) exp_q.push_back(sel_pin ? 16'h000c : 16'h0008);
      wait_ticks(n);
      want_gate <= 1'b0;
      wait_ticks(6);
    end
    check(16'(exp_q.size()), 16'h0000);
    stop_test;
  end
endmodule
